/* logic/pmi_pkg.sv */
// constants for the digital microphone interface: register map, fields, reset values
package pmi_pkg;
  localparam logic [11:0] OFS_START_TRIG  = 12'h000;
  localparam logic [11:0] OFS_STOP_TRIG   = 12'h004;
  localparam logic [11:0] OFS_START_SUB   = 12'h080;
  localparam logic [11:0] OFS_STOP_SUB    = 12'h084;
  localparam logic [11:0] OFS_STARTED     = 12'h100;
  localparam logic [11:0] OFS_STOPPED     = 12'h104;
  localparam logic [11:0] OFS_BUF_END     = 12'h108;
  localparam logic [11:0] OFS_STARTED_PUB = 12'h180;
  localparam logic [11:0] OFS_STOPPED_PUB = 12'h184;
  localparam logic [11:0] OFS_END_PUB     = 12'h188;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET     = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR     = 12'h308;
  localparam logic [11:0] OFS_ENABLE      = 12'h500;
  localparam logic [11:0] OFS_CLKGEN      = 12'h504;
  localparam logic [11:0] OFS_ROUTING     = 12'h508;
  localparam logic [11:0] OFS_LGAIN       = 12'h518;
  localparam logic [11:0] OFS_RGAIN       = 12'h51c;
  localparam logic [11:0] OFS_RATIO       = 12'h520;
  localparam logic [11:0] OFS_CLK_PAD     = 12'h540;
  localparam logic [11:0] OFS_DATA_PAD    = 12'h544;
  localparam logic [11:0] OFS_PTR         = 12'h560;
  localparam logic [11:0] OFS_MAXCNT      = 12'h564;

  // field positions
  localparam int CONNECT_BIT  = 31;
  localparam int CFG_EN_BIT   = 31;
  localparam int PAD_NUM_W    = 5;
  localparam int CHIDX_W      = 8;
  localparam int GAIN_W       = 7;
  localparam int CLKDIV_W     = 16;
  localparam int MODE_MONO    = 0;
  localparam int MODE_SWAP    = 1;
  localparam int IRQ_STARTED  = 0;
  localparam int IRQ_STOPPED  = 1;
  localparam int IRQ_END      = 2;
  localparam int IRQ_W        = 3;

  // reset values
  localparam logic [31:0]         PAD_SEL_RST = 32'hffffffff;
  localparam logic [GAIN_W-1:0]   GAIN_RST    = 7'h00;
  localparam logic [CLKDIV_W-1:0] CLKDIV_RST  = 16'h003c;

  localparam logic [6:0] RATIO_64   = 7'h40;
  localparam logic [6:0] RATIO_80   = 7'h50;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {PMI_IDLE, PMI_RUN} pmi_state_e;
endpackage

/* logic/pmi_core.sv */
// digital microphone interface: registers, pad routing, clocking, sampling and sample writes
//
// Notes on behaviour
// RULE1 - clock and data follow pad select registers
// RULE2 - disconnected select leaves signal on no pad
// RULE3 - pad selections act only while enabled
// RULE4 - selects kept in off state
// RULE5 - disabled pads fall back to general port
// RULE6 - software preconfigures pads in general port
// RULE7 - clock pad preset as output low
// RULE8 - data pad preset as input
// RULE9 - software keeps that pad setup unchanged
// RULE10 - one peripheral per pad at a time
// RULE11 - writing one to triggers starts or stops
// RULE12 - end flag after last buffer sample
// RULE13 - separate started and stopped flags
// RULE14 - interrupt mask with set and clear aliases
// RULE15 - software retunes clock with ratio change
// RULE16 - samples written to buffer pointer address
// RULE17 - sample count limit sizes each buffer
// RULE18 - subscribe and publish channel registers
// RULE19 - left, right gain and routing mode registers
// RULE20 - stop waits for frame, then stopped
// RULE21 - left on falling, right on rising edge
// RULE22 - clock to sample ratio 64 or 80
// RULE23 - pointer double buffered while running
// RULE24 - zero writes ignored, triggers read zero
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
module pmi_core
  import pmi_pkg::*;
#(
  parameter int NPAD  = 32,
  parameter int NCH   = 16,
  parameter int CNT_W = 15
) (
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  input  wire logic            s_axi_awvalid,
  output      logic            s_axi_awready,
  input  wire logic [31:0]     s_axi_awaddr,
  input  wire logic            s_axi_wvalid,
  output      logic            s_axi_wready,
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  output      logic            s_axi_bvalid,
  input  wire logic            s_axi_bready,
  output      logic [1:0]      s_axi_bresp,
  input  wire logic            s_axi_arvalid,
  output      logic            s_axi_arready,
  input  wire logic [31:0]     s_axi_araddr,
  output      logic            s_axi_rvalid,
  input  wire logic            s_axi_rready,
  output      logic [31:0]     s_axi_rdata,
  output      logic [1:0]      s_axi_rresp,
  input  wire logic [NPAD-1:0] pad_in,
  output      logic [NPAD-1:0] pad_out,
  output      logic [NPAD-1:0] pad_oe_n,
  input  wire logic [NPAD-1:0] gpio_out,
  input  wire logic [NPAD-1:0] gpio_oe_n,
  input  wire logic [NCH-1:0]  chan_in,
  output      logic [NCH-1:0]  chan_out,
  output      logic            dma_valid,
  input  wire logic            dma_ready,
  output      logic [31:0]     dma_addr,
  output      logic [31:0]     dma_data,
  output      logic            irq
);

  // ---------------- register storage
  logic [31:0]         start_sub_r, stop_sub_r, started_pub_r, stopped_pub_r, end_pub_r;
  logic [31:0]         clk_pad_r, data_pad_r, ptr_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic                started_flag_r, stopped_flag_r, buffer_end_flag_r, enable_r;
  logic [CLKDIV_W-1:0] clkgen_r;
  logic [1:0]          routing_r;
  logic [GAIN_W-1:0]   left_gain_r, right_gain_r;
  logic                ratio_r;
  logic [CNT_W-1:0]    maxcnt_r;

  // ---------------- bus slave
  logic        aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;

  function automatic logic mapped(input logic [11:0] a);
    case (a)
      OFS_START_TRIG, OFS_STOP_TRIG, OFS_START_SUB, OFS_STOP_SUB, OFS_STARTED, OFS_STOPPED,
      OFS_BUF_END, OFS_STARTED_PUB, OFS_STOPPED_PUB, OFS_END_PUB, OFS_IRQ_MASK, OFS_IRQ_SET,
      OFS_IRQ_CLR, OFS_ENABLE, OFS_CLKGEN, OFS_ROUTING, OFS_LGAIN, OFS_RGAIN, OFS_RATIO,
      OFS_CLK_PAD, OFS_DATA_PAD, OFS_PTR, OFS_MAXCNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    case (a)
      OFS_START_SUB:   rd_mux = start_sub_r;
      OFS_STOP_SUB:    rd_mux = stop_sub_r;
      OFS_STARTED:     rd_mux = {31'h0, started_flag_r};
      OFS_STOPPED:     rd_mux = {31'h0, stopped_flag_r};
      OFS_BUF_END:     rd_mux = {31'h0, buffer_end_flag_r};
      OFS_STARTED_PUB: rd_mux = started_pub_r;
      OFS_STOPPED_PUB: rd_mux = stopped_pub_r;
      OFS_END_PUB:     rd_mux = end_pub_r;
      OFS_IRQ_MASK, OFS_IRQ_SET, OFS_IRQ_CLR: rd_mux = {29'h0, irq_mask_r};
      OFS_ENABLE:      rd_mux = {31'h0, enable_r};
      OFS_CLKGEN:      rd_mux = {16'h0, clkgen_r};
      OFS_ROUTING:     rd_mux = {30'h0, routing_r};
      OFS_LGAIN:       rd_mux = {25'h0, left_gain_r};
      OFS_RGAIN:       rd_mux = {25'h0, right_gain_r};
      OFS_RATIO:       rd_mux = {31'h0, ratio_r};
      OFS_CLK_PAD:     rd_mux = clk_pad_r;
      OFS_DATA_PAD:    rd_mux = data_pad_r;
      OFS_PTR:         rd_mux = ptr_r;
      OFS_MAXCNT:      rd_mux = 32'(maxcnt_r);
      default:         rd_mux = 32'h0; // triggers and unmapped read zero [RULE24]
    endcase
  endfunction

  // channel index match for subscriptions and publications
  function automatic logic ch_match(input logic [31:0] cfg, input int ch);
    ch_match = cfg[CFG_EN_BIT] && (cfg[CHIDX_W-1:0] == CHIDX_W'(ch));
  endfunction

  wire        wr_fire  = aw_hold_r & w_hold_r & ~bvalid_r;
  wire [31:0] strb_m   = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  // byte lanes merge into the current value so partial writes keep the other bytes
  wire [31:0] wr_val   = (rd_mux(aw_addr_r) & ~strb_m) | (w_data_r & strb_m);
  wire        ar_fire  = s_axi_arvalid & s_axi_arready;
  wire [11:0] ar_addr  = {s_axi_araddr[11:2], 2'b00};

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready  = ~w_hold_r & ~bvalid_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 12'h000;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[11:2], 2'b00};
      end else if (wr_fire) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_r <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (ar_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_mux(ar_addr);
        rresp_r  <= mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  function automatic logic wr_to(input logic [11:0] a);
    wr_to = wr_fire && (aw_addr_r == a);
  endfunction

  // ---------------- tasks from register writes or subscribed channels
  logic sub_start, sub_stop;
  always_comb begin
    sub_start = 1'b0;
    sub_stop  = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      sub_start = sub_start | (chan_in[i] & ch_match(start_sub_r, i)); // [RULE18]
      sub_stop  = sub_stop  | (chan_in[i] & ch_match(stop_sub_r, i));  // [RULE18]
    end
  end
  wire task_start = (wr_to(OFS_START_TRIG) & wr_val[0]) | sub_start; // [RULE11] [RULE24]
  wire task_stop  = (wr_to(OFS_STOP_TRIG) & wr_val[0]) | sub_stop;   // [RULE11] [RULE24]

  // ---------------- pad routing
  wire [PAD_NUM_W-1:0] clk_pad_num = clk_pad_r[PAD_NUM_W-1:0];
  wire [PAD_NUM_W-1:0] din_pad_num = data_pad_r[PAD_NUM_W-1:0];
  wire clk_live = enable_r & ~clk_pad_r[CONNECT_BIT];  // [RULE2] [RULE3]
  wire din_live = enable_r & ~data_pad_r[CONNECT_BIT]; // [RULE2] [RULE3]
  logic mclk_r;

  genvar gp;
  generate
    for (gp = 0; gp < NPAD; gp++) begin : g_pad
      wire clk_here = clk_live && (clk_pad_num == PAD_NUM_W'(gp));
      wire din_here = din_live && (din_pad_num == PAD_NUM_W'(gp));
      assign pad_out[gp]  = clk_here ? mclk_r : gpio_out[gp];                      // [RULE1] [RULE5]
      assign pad_oe_n[gp] = clk_here ? 1'b0 : (din_here ? 1'b1 : gpio_oe_n[gp]);   // [RULE1] [RULE5]
    end
  endgenerate

  // pads are outside this clock's timing, so all pass two flip-flops before the select
  logic [NPAD-1:0] pad_s1_r, pad_s2_r;
  wire  din_sync = din_live & pad_s2_r[din_pad_num]; // [RULE1]

  // ---------------- run control, clock generator, sampling
  pmi_state_e         state_r;
  logic [CLKDIV_W-1:0] div_cnt_r;
  logic [6:0]         bit_cnt_r, ones_l_r, ones_r_r;
  logic [15:0]        pcm_l_r, pcm_r_r;
  logic               pcm_vld_r, half_r, stop_req_r;
  logic [31:0]        cur_ptr_r, word_r;
  logic [CNT_W-1:0]   cur_max_r, smp_cnt_r;

  wire running  = (state_r == PMI_RUN);
  wire [CLKDIV_W-1:0] half_per = (clkgen_r == '0) ? CLKDIV_W'(1) : clkgen_r;
  wire toggle   = running && (div_cnt_r == half_per - CLKDIV_W'(1));
  wire rise     = toggle & ~mclk_r;
  wire fall     = toggle & mclk_r;
  wire [6:0] ratio_n = ratio_r ? RATIO_80 : RATIO_64;                  // [RULE22]
  wire swap     = routing_r[MODE_SWAP];
  wire take_l   = swap ? rise : fall;                                  // [RULE21]
  wire take_r   = swap ? fall : rise;                                  // [RULE21]
  wire frame_end = rise && (bit_cnt_r == ratio_n - 7'd1);              // [RULE22]
  // density to signed level: twice the ones minus the ratio, in the upper byte
  wire [7:0] lvl_l = 8'({ones_l_r + 7'(take_l & din_sync), 1'b0} - {1'b0, ratio_n});
  wire [7:0] lvl_r = 8'({ones_r_r + 7'(take_r & din_sync), 1'b0} - {1'b0, ratio_n});

  // one word per stereo pair, or per two mono samples
  wire mono      = routing_r[MODE_MONO];
  wire word_go   = pcm_vld_r && (!mono || half_r);
  wire [CNT_W-1:0] cnt_nxt = smp_cnt_r + CNT_W'(2);
  wire buf_full  = word_go && (cnt_nxt >= cur_max_r);                  // [RULE17]
  wire end_evt   = buf_full | (word_go & stop_req_r);                  // [RULE12]
  wire stop_evt  = (word_go & stop_req_r) | (task_stop & ~running);    // [RULE20]
  wire start_evt = (task_start & ~running) | (buf_full & ~stop_req_r); // [RULE13]

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_s1_r  <= '0;
      pad_s2_r  <= '0;
      state_r   <= PMI_IDLE;
      div_cnt_r <= '0;
      mclk_r    <= 1'b0;
      bit_cnt_r <= 7'h00;
      ones_l_r  <= 7'h00;
      ones_r_r  <= 7'h00;
      pcm_l_r   <= 16'h0;
      pcm_r_r   <= 16'h0;
      pcm_vld_r <= 1'b0;
      half_r    <= 1'b0;
      stop_req_r <= 1'b0;
      cur_ptr_r <= 32'h0;
      cur_max_r <= '0;
      smp_cnt_r <= '0;
      word_r    <= 32'h0;
    end else begin
      pad_s1_r  <= pad_in;
      pad_s2_r  <= pad_s1_r;
      div_cnt_r <= (!running || toggle) ? '0 : div_cnt_r + CLKDIV_W'(1);
      mclk_r    <= running ? (mclk_r ^ toggle) : 1'b0;
      pcm_vld_r <= frame_end;
      if (!running) begin
        bit_cnt_r <= 7'h00;
        ones_l_r  <= 7'h00;
        ones_r_r  <= 7'h00;
      end else if (frame_end) begin
        bit_cnt_r <= 7'h00;
        ones_l_r  <= 7'h00;
        ones_r_r  <= 7'h00;
        pcm_l_r   <= {lvl_l, 8'h00};
        pcm_r_r   <= {lvl_r, 8'h00};
      end else begin
        bit_cnt_r <= bit_cnt_r + 7'(rise);
        ones_l_r  <= ones_l_r + 7'(take_l & din_sync);
        ones_r_r  <= ones_r_r + 7'(take_r & din_sync);
      end
      if (pcm_vld_r) begin
        half_r <= mono & ~half_r;
        word_r <= mono ? (half_r ? {pcm_l_r, word_r[15:0]} : {16'h0, pcm_l_r})
                       : {pcm_r_r, pcm_l_r};
      end
      if (task_stop & running)
        stop_req_r <= 1'b1;
      if (start_evt) begin
        // the live pointer is copied here, so later writes only aim the next buffer
        cur_ptr_r <= ptr_r;    // [RULE23]
        cur_max_r <= maxcnt_r; // [RULE17]
        smp_cnt_r <= '0;
        state_r   <= PMI_RUN;
      end else if (word_go) begin
        smp_cnt_r <= cnt_nxt;
      end
      if (stop_evt) begin
        state_r    <= PMI_IDLE; // [RULE20]
        stop_req_r <= 1'b0;
        half_r     <= 1'b0;
      end
    end
  end

  // ---------------- sample writes; a word not taken before the next one is lost
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dma_valid <= 1'b0;
      dma_addr  <= 32'h0;
      dma_data  <= 32'h0;
    end else if (word_go) begin
      dma_valid <= 1'b1;
      dma_addr  <= cur_ptr_r + 32'({smp_cnt_r, 1'b0}); // [RULE16]
      dma_data  <= mono && !half_r ? word_r : (mono ? {pcm_l_r, word_r[15:0]}
                                                    : {pcm_r_r, pcm_l_r});
    end else if (dma_ready) begin
      dma_valid <= 1'b0;
    end
  end

  // ---------------- software registers and event flags (hardware set wins)
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      start_sub_r       <= 32'h0;
      stop_sub_r        <= 32'h0;
      started_pub_r     <= 32'h0;
      stopped_pub_r     <= 32'h0;
      end_pub_r         <= 32'h0;
      clk_pad_r         <= PAD_SEL_RST; // reset stands in for the off state [RULE4]
      data_pad_r        <= PAD_SEL_RST;
      ptr_r             <= 32'h0;
      irq_mask_r        <= '0;
      started_flag_r    <= 1'b0;
      stopped_flag_r    <= 1'b0;
      buffer_end_flag_r <= 1'b0;
      enable_r          <= 1'b0;
      clkgen_r          <= CLKDIV_RST;
      routing_r         <= 2'b00;
      left_gain_r       <= GAIN_RST;
      right_gain_r      <= GAIN_RST;
      ratio_r           <= 1'b0;
      maxcnt_r          <= '0;
      chan_out          <= '0;
    end else begin
      if (wr_to(OFS_START_SUB))   start_sub_r   <= wr_val;                  // [RULE18]
      if (wr_to(OFS_STOP_SUB))    stop_sub_r    <= wr_val;                  // [RULE18]
      if (wr_to(OFS_STARTED_PUB)) started_pub_r <= wr_val;                  // [RULE18]
      if (wr_to(OFS_STOPPED_PUB)) stopped_pub_r <= wr_val;                  // [RULE18]
      if (wr_to(OFS_END_PUB))     end_pub_r     <= wr_val;                  // [RULE18]
      if (wr_to(OFS_CLK_PAD))     clk_pad_r     <= wr_val;                  // [RULE1]
      if (wr_to(OFS_DATA_PAD))    data_pad_r    <= wr_val;                  // [RULE1]
      if (wr_to(OFS_PTR))         ptr_r         <= wr_val;                  // [RULE16]
      if (wr_to(OFS_ENABLE))      enable_r      <= wr_val[0];
      if (wr_to(OFS_CLKGEN))      clkgen_r      <= wr_val[CLKDIV_W-1:0];
      if (wr_to(OFS_ROUTING))     routing_r     <= wr_val[1:0];             // [RULE19]
      if (wr_to(OFS_LGAIN))       left_gain_r   <= wr_val[GAIN_W-1:0];      // [RULE19]
      if (wr_to(OFS_RGAIN))       right_gain_r  <= wr_val[GAIN_W-1:0];      // [RULE19]
      if (wr_to(OFS_RATIO))       ratio_r       <= wr_val[0];               // [RULE22]
      if (wr_to(OFS_MAXCNT))      maxcnt_r      <= wr_val[CNT_W-1:0];       // [RULE17]
      if (wr_to(OFS_IRQ_MASK))
        irq_mask_r <= wr_val[IRQ_W-1:0];
      else if (wr_to(OFS_IRQ_SET))
        irq_mask_r <= irq_mask_r | wr_val[IRQ_W-1:0];                       // [RULE14]
      else if (wr_to(OFS_IRQ_CLR))
        irq_mask_r <= irq_mask_r & ~wr_val[IRQ_W-1:0];                      // [RULE14]
      started_flag_r    <= start_evt | (wr_to(OFS_STARTED) ? wr_val[0] : started_flag_r); // [RULE13]
      stopped_flag_r    <= stop_evt | (wr_to(OFS_STOPPED) ? wr_val[0] : stopped_flag_r);  // [RULE13]
      buffer_end_flag_r <= end_evt | (wr_to(OFS_BUF_END) ? wr_val[0] : buffer_end_flag_r); // [RULE12]
      for (int i = 0; i < NCH; i++)
        chan_out[i] <= (start_evt & ch_match(started_pub_r, i)) |
                       (stop_evt & ch_match(stopped_pub_r, i)) |
                       (end_evt & ch_match(end_pub_r, i));                  // [RULE18]
    end
  end

  assign irq = |(irq_mask_r & {buffer_end_flag_r, stopped_flag_r, started_flag_r});

  // ---------------- checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_start_idle;
    task_start && !running;
  endsequence
  sequence s_run_started;
    running && started_flag_r;
  endsequence

  property p_start_runs;
    s_start_idle |=> s_run_started;
  endproperty
  a_start_runs: assert property (p_start_runs) else $error("start did not run"); // [RULE11]

  property p_zero_ignored;
    wr_to(OFS_START_TRIG) && !wr_val[0] && !sub_start && !running |=> !running;
  endproperty
  a_zero_ignored: assert property (p_zero_ignored) else $error("zero write started"); // [RULE24]

  property p_trig_reads_zero;
    ar_fire && (ar_addr == OFS_STOP_TRIG || ar_addr == OFS_START_TRIG) |=> rdata_r == 32'h0;
  endproperty
  a_trig_reads_zero: assert property (p_trig_reads_zero) else $error("trigger read nonzero"); // [RULE24]

  property p_clk_routed;
    clk_live |-> pad_out[clk_pad_num] == mclk_r && !pad_oe_n[clk_pad_num];
  endproperty
  a_clk_routed: assert property (p_clk_routed) else $error("clock pad not routed"); // [RULE1]

  property p_disabled_gpio;
    !enable_r |-> pad_out == gpio_out && pad_oe_n == gpio_oe_n;
  endproperty
  a_disabled_gpio: assert property (p_disabled_gpio) else $error("pads not general"); // [RULE5]

  property p_end_flag;
    end_evt |=> buffer_end_flag_r ##0 $past(smp_cnt_r) + CNT_W'(2) >= $past(cur_max_r) ||
                $past(stop_req_r);
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("end flag wrong"); // [RULE12]

  property p_stop_at_frame;
    running && stop_req_r && word_go |=> !running && stopped_flag_r && buffer_end_flag_r;
  endproperty
  a_stop_at_frame: assert property (p_stop_at_frame) else $error("stop not taken"); // [RULE20]

  property p_stop_waits;
    running && stop_req_r && !word_go |=> running;
  endproperty
  a_stop_waits: assert property (p_stop_waits) else $error("stop before frame"); // [RULE20]

  property p_mask_set;
    wr_to(OFS_IRQ_SET) |=> irq_mask_r == ($past(irq_mask_r) | $past(wr_val[IRQ_W-1:0]));
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask set failed"); // [RULE14]

  property p_ptr_held;
    running && !start_evt |=> $stable(cur_ptr_r);
  endproperty
  a_ptr_held: assert property (p_ptr_held) else $error("pointer disturbed"); // [RULE23]

  property p_ratio_bound;
    running |-> bit_cnt_r < ratio_n;
  endproperty
  a_ratio_bound: assert property (p_ratio_bound) else $error("ratio overrun"); // [RULE22]

endmodule // pmi_core

/* verif/pmi_mic.sv */
// behavioural microphone pair on the data pad
`timescale 1ns/100ps
module pmi_mic (
  input  wire logic sys_clk,
  input  wire logic mic_clk,
  input  wire logic loud,
  output      logic mic_data
);
  logic       clk_d = 1'b0;
  logic [3:0] idle  = 4'hf;
  initial mic_data = 1'b0;
  always @(posedge sys_clk) begin
    clk_d <= mic_clk;
    idle <= (mic_clk != clk_d) ? 4'h0 : (idle == 4'hf ? idle : idle + 4'h1);
    // left drives while the clock is high, right while it is low
    // a stopped clock means released: toggle so no stale level is read
    mic_data <= (idle < 4'hc) ? (mic_clk ? loud : ~loud) : ~mic_data;
  end
endmodule // pmi_mic

/* verif/tb.sv */
// self-checking bench: register access, pad routing and capture runs
`timescale 1ns/100ps
module tb;
  import pmi_pkg::*;
  logic        sys_clk, arst_n, awvalid, wvalid, bready, arvalid, rready, loud;
  logic        awready, wready, bvalid, arready, rvalid, dma_valid, irq, mic_data;
  logic [31:0] awaddr, wdata, araddr, rdata, pad_in, pad_out, pad_oe_n;
  logic [31:0] gpio_out, gpio_oe_n, dma_addr, dma_data, rd_v, dw, da;
  logic [15:0] chan_out, chan;
  logic [1:0]  bresp, rresp, rsp;
  int          fails, checks, cyc;
  assign pad_in = {gpio_out[31:6], mic_data, gpio_out[4:0]}; // mic owns only the data pad
  pmi_core pmi_core_inst (.sys_clk(sys_clk), .arst_n(arst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .chan_in(chan), .chan_out(chan_out), .dma_valid(dma_valid),
    .dma_ready(1'b1), .dma_addr(dma_addr), .dma_data(dma_data), .irq(irq));
  pmi_mic pmi_mic_inst (.sys_clk(sys_clk), .mic_clk(pad_out[3]), .loud(loud),
    .mic_data(mic_data));
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit ah, wh;
    ah = 0;
    wh = 0;
    awaddr <= {20'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ah && wh)) begin
      @(negedge sys_clk);
      ah |= awvalid && awready;
      wh |= wvalid && wready;
      @(posedge sys_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b1;
    do @(negedge sys_clk); while (!bvalid);
    @(posedge sys_clk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    araddr <= {20'h0, a};
    arvalid <= 1'b1;
    do @(negedge sys_clk); while (!arready);
    @(posedge sys_clk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge sys_clk); while (!rvalid);
    rsp = rresp;
    chk(rdata, exp);
    @(posedge sys_clk);
    rready <= 1'b0;
  endtask
  task automatic dma_take();
    int n;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (!dma_valid && n < 2000);
    dw = dma_data;
    da = dma_addr;
    @(posedge sys_clk);
  endtask
  task automatic run(input logic r, input logic l, input logic [31:0] exp);
    wr(OFS_RATIO, {31'h0, r});
    wr(OFS_ROUTING, {30'h0, r, 1'b0});  // second run swaps the edges
    wr(OFS_CLKGEN, 32'ha);
    wr(OFS_PTR, 32'h20000100);
    wr(OFS_MAXCNT, 32'h4);
    loud <= l;
    if (r) begin // second run starts from subscribed channel 3
      chan <= 16'h0008;
      @(posedge sys_clk);
      chan <= 16'h0000;
      @(negedge sys_clk);
      chk({16'h0, chan_out}, 32'h00000080);
      @(posedge sys_clk);
    end else begin
      wr(OFS_START_TRIG, 32'h1);
    end
    rd(OFS_STARTED, 32'h1);
    wr(OFS_PTR, 32'h20000200);          // next buffer while running
    dma_take();
    chk(da, 32'h20000100);
    dma_take();
    chk(da, 32'h20000104);
    chk(dw, exp);
    dma_take();
    chk(da, 32'h20000200);
    rd(OFS_BUF_END, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_STOP_TRIG, 32'h1);
    dma_take();
    rd(OFS_STOPPED, 32'h1);
    wr(OFS_STARTED, 32'h0);
    wr(OFS_STOPPED, 32'h0);
    wr(OFS_BUF_END, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("capture run done, ratio bit %0d", r);
  endtask
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, loud, arst_n} = 7'h0;
    {awaddr, wdata, araddr, chan, cyc, fails, checks} = 0;
    gpio_out = 32'h5a5a5a52;            // clock pad latch low, never changed
    gpio_oe_n = 32'h0000fff7;           // clock pad output, data pad input
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rd(OFS_CLK_PAD, PAD_SEL_RST);
    rd(OFS_CLKGEN, {16'h0, CLKDIV_RST});
    wr(OFS_START_TRIG, 32'h0);
    rd(OFS_START_TRIG, 32'h0);
    rd(OFS_STARTED, 32'h0);
    rd(12'h00c, 32'h0);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFS_IRQ_SET, 32'h5);
    wr(OFS_IRQ_CLR, 32'h1);
    rd(OFS_IRQ_MASK, 32'h4);
    wr(OFS_LGAIN, 32'h28);
    rd(OFS_LGAIN, 32'h28);
    wr(OFS_START_SUB, 32'h80000003);
    rd(OFS_START_SUB, 32'h80000003);
    wr(OFS_STARTED_PUB, 32'h80000007);
    wr(OFS_CLK_PAD, 32'h3);
    wr(OFS_DATA_PAD, 32'h5);
    chk(pad_oe_n, gpio_oe_n);
    chk(pad_out, gpio_out);
    wr(OFS_ENABLE, 32'h1);
    chk(pad_oe_n, gpio_oe_n);           // clock pad driven, data pad input
    $display("register test done");
    run(1'b0, 1'b1, 32'hc0004000);
    run(1'b1, 1'b0, 32'hb0005000);
    final_report();
  end
endmodule // tb
